// file: pkg/nvspc_regs.svh
/*
 Constants for the store and patch command executor.
 Assumes inclusion by bare name from the executor and testbench modules.
*/
`ifndef NVSPC_REGS_SVH
`define NVSPC_REGS_SVH
`define NVSPC_OP_STORE_ONE 8'hC6
`define NVSPC_OP_PATCH_LONG 8'h8A
`define NVSPC_OP_PATCH_WORD 8'h8B
`define NVSPC_OP_WRITE_REG 8'h9A
`define NVSPC_INDIRECT_REG 8'h0A
`define NVSPC_ERR_BIT_A 12
`define NVSPC_ERR_BIT_B 14
`define NVSPC_OK_BIT 15
`endif

// file: pkg/nvspc_pkg.sv
/*
 Types for the store and patch command executor.
 Assumes nvspc_regs.svh on the include path.
*/
package nvspc_pkg;
   typedef enum logic [1:0] {NVSPC_OWN_NONE, NVSPC_OWN_T1, NVSPC_OWN_T2} nvspc_owner_t;
   typedef enum {NVSPC_IDLE, NVSPC_SUM, NVSPC_NV_LO, NVSPC_NV_HI, NVSPC_NV_SUM, NVSPC_PB_LO, NVSPC_PB_HI,
      NVSPC_DONE} nvspc_state_t;
endpackage

// file: pkg/nvspc_nv_if.sv
/*
 Carrier between the executor and its memory arbiter.
 Assumes one clock shared by both ends.
*/
`timescale 1ns/100ps
interface nvspc_nv_if;
   logic req1;
   logic req2;
   logic rel;
   logic grant1;
   logic grant2;
   modport arb (input req1, input req2, input rel, output grant1, output grant2);
   modport user (output req1, output req2, output rel, input grant1, input grant2);
endinterface

// file: verilog/nvspc_arbiter.sv
/*
 Single-owner grant of the non-volatile memory to one of two threads.
 Assumes requests hold until granted and a release pulse ends ownership.
*/
`timescale 1ns/100ps
module nvspc_arbiter
   import nvspc_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Requests and grants
   nvspc_nv_if.arb nv
);
   nvspc_owner_t owner_q;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         owner_q <= NVSPC_OWN_NONE;
      end else if (owner_q == NVSPC_OWN_NONE) begin
         // Thread 1 first on a tie; the other waits automatically
         if (nv.req1) begin
            owner_q <= NVSPC_OWN_T1; // R4
         end else if (nv.req2) begin
            owner_q <= NVSPC_OWN_T2; // R4
         end
      end else if (nv.rel) begin
         owner_q <= NVSPC_OWN_NONE;
      end
   end

   assign nv.grant1 = (owner_q == NVSPC_OWN_T1);
   assign nv.grant2 = (owner_q == NVSPC_OWN_T2);

   a_grant_exclusive: assert property (@(posedge clk_sys) disable iff (rst) !(nv.grant1 && nv.grant2)) // R4
      else $error("both threads hold memory");
   a_grant_idle_take: assert property (@(posedge clk_sys) disable iff (rst)
      (!nv.grant1 && !nv.grant2 && nv.req1) |=> nv.grant1) // R4
      else $error("free memory not granted");
endmodule // nvspc_arbiter

// file: verilog/nvspc_exec.sv
/*
 Executes store-one-register-to-NV, program patch longword/word and register write.
 Assumes a decoded command pulse, register file read port, NV and program buffer
 word write ports that accept one word per cycle.
*/
// What this block does
// R1 - Store command writes register data and its checksum to NV memory.
// R2 - Single store uses the multi-store procedure with a count of one.
// R3 - Stored layout is readable by single load or multi load of one.
// R4 - Only one thread owns NV memory; the other stalls until free.
// R5 - Host sends unit, opcode 198, register and NV address: three words.
// R6 - Longword patch writes a register's 32 bits into the program buffer.
// R7 - Longword patch fills the given location and the next one.
// R8 - Word patch writes only the register's low 16 bits at one location.
// R9 - Patches copy data with no range check.
// R10 - Opcode 154 writes a 32-bit value into the selected register.
// R11 - Negative register number continues on error and reports via status bit.
// R12 - NV address zero takes the real address from register 10.
// R13 - Protected NV write gives command error and sets status bits 12 and 14.
// R14 - Every command answers with an acknowledgement and no payload.
`timescale 1ns/100ps
`include "nvspc_regs.svh"
module nvspc_exec
   import nvspc_pkg::*;
#(
   parameter int ADDR_W = 16,
   parameter int PROT_LIMIT = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Command in
   input wire logic cmdValid,
   output logic cmdReady,
   input wire logic cmdThread,
   input wire logic [7:0] cmdOpcode,
   input wire logic signed [15:0] cmdRegNum,
   input wire logic [15:0] cmdAddr,
   input wire logic [31:0] cmdData,
   // Completion
   output logic ackPulse,
   output logic cmdError,
   output logic haltReq,
   output logic [15:0] internal_status_word,
   // Register file
   output logic [7:0] regRdAddr,
   input wire logic [31:0] regRdData,
   output logic regWrEn,
   output logic [7:0] regWrAddr,
   output logic [31:0] regWrData,
   // NV memory
   output logic nvWrEn,
   output logic [ADDR_W-1:0] nvWrAddr,
   output logic [15:0] nvWrData,
   // Program buffer
   output logic pbWrEn,
   output logic [ADDR_W-1:0] pbWrAddr,
   output logic [15:0] pbWrData
);
   if (ADDR_W < 16 || PROT_LIMIT < 0) begin : g_bad_params
      $error("nvspc_exec: bad parameters");
   end

   nvspc_nv_if nv();
   nvspc_state_t state_q;
   logic [7:0] op_q;
   logic thread_q;
   logic suppress_q;
   logic [7:0] reg_q;
   logic [ADDR_W-1:0] addr_q;
   logic [31:0] data_q;
   logic [15:0] sum_q;
   logic waitGrant;
   logic granted;
   logic readIndirect;

   nvspc_arbiter u_arb (
      .clk_sys(clk_sys),
      .rst(rst),
      .nv(nv.arb)
   );

   assign granted = thread_q ? nv.grant2 : nv.grant1;
   assign waitGrant = (state_q == NVSPC_SUM) && !granted;
   assign nv.req1 = (state_q == NVSPC_SUM) && !thread_q; // R4
   assign nv.req2 = (state_q == NVSPC_SUM) && thread_q; // R4
   assign nv.rel = (state_q == NVSPC_NV_SUM);
   assign cmdReady = (state_q == NVSPC_IDLE);
   assign regRdAddr = readIndirect ? `NVSPC_INDIRECT_REG : reg_q; // R12

   // Command capture
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         op_q <= 8'h00;
         thread_q <= 1'b0;
         suppress_q <= 1'b0;
         reg_q <= 8'h00;
         addr_q <= '0;
         data_q <= 32'h00000000;
      end else if (cmdValid && cmdReady) begin
         op_q <= cmdOpcode;
         thread_q <= cmdThread;
         suppress_q <= cmdRegNum[15]; // R11
         reg_q <= cmdRegNum[15] ? 8'(-cmdRegNum) : cmdRegNum[7:0];
         addr_q <= ADDR_W'(cmdAddr);
         data_q <= cmdData;
      end else if (readIndirect) begin
         addr_q <= ADDR_W'(regRdData[15:0]); // R12
      end else if (state_q == NVSPC_SUM && granted) begin
         data_q <= regRdData;
      end else if (state_q == NVSPC_PB_LO) begin
         data_q <= regRdData;
      end
   end

   // Sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_q <= NVSPC_IDLE;
      end else begin
         case (state_q)
            NVSPC_IDLE: begin
               if (cmdValid) begin
                  case (cmdOpcode)
                     `NVSPC_OP_STORE_ONE: state_q <= NVSPC_SUM; // R2
                     `NVSPC_OP_PATCH_LONG, `NVSPC_OP_PATCH_WORD: state_q <= NVSPC_PB_LO;
                     default: state_q <= NVSPC_DONE;
                  endcase
               end
            end
            NVSPC_SUM: if (granted) state_q <= NVSPC_NV_LO;
            NVSPC_NV_LO: state_q <= NVSPC_NV_HI;
            NVSPC_NV_HI: state_q <= NVSPC_NV_SUM;
            NVSPC_NV_SUM: state_q <= NVSPC_DONE;
            NVSPC_PB_LO: state_q <= NVSPC_PB_HI;
            NVSPC_PB_HI: state_q <= NVSPC_DONE;
            NVSPC_DONE: state_q <= NVSPC_IDLE;
            default: state_q <= NVSPC_IDLE;
         endcase
      end
   end

   // Indirect address lives in register 10; the grant is never same-cycle, so the first wait reads it
   assign readIndirect = (state_q == NVSPC_SUM) && !granted && (addr_q == '0); // R12

   // Checksum: one's complement of the word sum, so loads can verify
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         sum_q <= 16'h0000;
      end else if (state_q == NVSPC_NV_LO) begin
         sum_q <= 16'(~(data_q[15:0] + data_q[31:16])); // R1
      end
   end

   logic protHit;
   assign protHit = (nvWrAddr < ADDR_W'(PROT_LIMIT));

   a_no_prot_write: assert property (@(posedge clk_sys) disable iff (rst) nvWrEn |-> !protHit) // R13
      else $error("write into protected memory");

   // NV word writes: low, high, checksum in that order
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         nvWrEn <= 1'b0;
         nvWrAddr <= '0;
         nvWrData <= 16'h0000;
      end else begin
         nvWrEn <= 1'b0;
         case (state_q)
            NVSPC_NV_LO: begin
               nvWrEn <= (addr_q >= ADDR_W'(PROT_LIMIT)); // R13
               nvWrAddr <= addr_q; // R3
               nvWrData <= data_q[15:0]; // R1
            end
            NVSPC_NV_HI: begin
               nvWrEn <= (addr_q >= ADDR_W'(PROT_LIMIT));
               nvWrAddr <= addr_q + ADDR_W'(1); // R3
               nvWrData <= data_q[31:16];
            end
            NVSPC_NV_SUM: begin
               nvWrEn <= (addr_q >= ADDR_W'(PROT_LIMIT));
               nvWrAddr <= addr_q + ADDR_W'(2); // R3
               nvWrData <= sum_q; // R1
            end
            default: nvWrEn <= 1'b0;
         endcase
      end
   end

   // Program buffer patch, no range check on the data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pbWrEn <= 1'b0;
         pbWrAddr <= '0;
         pbWrData <= 16'h0000;
      end else begin
         pbWrEn <= 1'b0;
         if (state_q == NVSPC_PB_HI) begin
            pbWrEn <= 1'b1;
            pbWrAddr <= addr_q; // R7
            pbWrData <= data_q[15:0]; // R8 R9
         end else if (state_q == NVSPC_DONE && op_q == `NVSPC_OP_PATCH_LONG) begin
            pbWrEn <= 1'b1; // R6
            pbWrAddr <= addr_q + ADDR_W'(1); // R7
            pbWrData <= data_q[31:16]; // R6
         end
      end
   end

   // Register write for opcode 154
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         regWrEn <= 1'b0;
         regWrAddr <= 8'h00;
         regWrData <= 32'h00000000;
      end else begin
         regWrEn <= (state_q == NVSPC_DONE) && (op_q == `NVSPC_OP_WRITE_REG); // R10
         regWrAddr <= reg_q;
         regWrData <= data_q; // R10
      end
   end

   // Acknowledge and status
   logic errNow;
   assign errNow = (state_q == NVSPC_DONE) && (op_q == `NVSPC_OP_STORE_ONE) && (addr_q < ADDR_W'(PROT_LIMIT));

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ackPulse <= 1'b0;
         cmdError <= 1'b0;
         haltReq <= 1'b0;
         internal_status_word <= 16'h0000;
      end else begin
         ackPulse <= (state_q == NVSPC_DONE); // R14
         cmdError <= errNow; // R13
         haltReq <= errNow && !suppress_q; // R11
         if (state_q == NVSPC_DONE && op_q == `NVSPC_OP_STORE_ONE) begin
            internal_status_word[`NVSPC_OK_BIT] <= errNow; // R11
            if (errNow) begin
               internal_status_word[`NVSPC_ERR_BIT_A] <= 1'b1; // R13
               internal_status_word[`NVSPC_ERR_BIT_B] <= 1'b1; // R13
            end
         end
      end
   end

   a_ack_after_done: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == NVSPC_DONE) |=> ackPulse) // R14
      else $error("no ack after command");
   a_store_three_writes: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == NVSPC_NV_LO && addr_q >= ADDR_W'(PROT_LIMIT)) |=> nvWrEn [*3]) // R1
      else $error("store not three words");
   a_sum_checks: assert property (@(posedge clk_sys) disable iff (rst)
      (nvWrEn && state_q == NVSPC_DONE) |-> nvWrData == 16'(~($past(nvWrData) + $past(nvWrData, 2)))) // R3
      else $error("checksum mismatch");
   a_protect_error: assert property (@(posedge clk_sys) disable iff (rst)
      errNow |=> cmdError && internal_status_word[12] && internal_status_word[14]) // R13
      else $error("protected write not flagged");
   a_no_halt_suppr: assert property (@(posedge clk_sys) disable iff (rst)
      (errNow && suppress_q) |=> !haltReq) // R11
      else $error("halt despite negative register");
   a_word_patch_one: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == NVSPC_DONE && op_q == `NVSPC_OP_PATCH_WORD) |=> !pbWrEn) // R8
      else $error("word patch wrote twice");
   a_long_patch_next: assert property (@(posedge clk_sys) disable iff (rst)
      (pbWrEn && op_q == `NVSPC_OP_PATCH_LONG && state_q == NVSPC_DONE) |=>
      pbWrEn && pbWrAddr == $past(pbWrAddr) + ADDR_W'(1)) // R7
      else $error("longword patch not consecutive");
   a_reg_write: assert property (@(posedge clk_sys) disable iff (rst)
      (state_q == NVSPC_DONE && op_q == `NVSPC_OP_WRITE_REG) |=> regWrEn && regWrData == $past(data_q)) // R10
      else $error("register write missing");
endmodule // nvspc_exec

// file: dv/nvspc_reg_model.sv
/*
 Register file seen by the executor: combinational read, one-cycle write.
 Assumes the executor's clk_sys and its register read and write ports.
*/
`timescale 1ns/100ps
module nvspc_reg_model (
   // Clock
   input wire logic clk_sys,
   // Read port
   input wire logic [7:0] regRdAddr,
   output logic [31:0] regRdData,
   // Write port
   input wire logic regWrEn,
   input wire logic [7:0] regWrAddr,
   input wire logic [31:0] regWrData
);
   logic [31:0] mem [256];
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 32'h0;
   end
   // Same-cycle read, as the executor latches in the cycle it asks
   assign regRdData = mem[regRdAddr];
   always @(posedge clk_sys) begin
      if (regWrEn === 1'b1) mem[regWrAddr] <= regWrData;
   end
endmodule // nvspc_reg_model

// file: dv/testbench.sv
/*
 Self-checking bench for the store and patch command executor.
 Assumes the executor and the register file model on the compile list.
*/
`timescale 1ns/100ps
`include "nvspc_regs.svh"
module testbench;
   logic clk_sys, rst, cmdValid, cmdThread, cmdReady, ackPulse, cmdError, haltReq, regWrEn, nvWrEn, pbWrEn;
   logic [7:0] cmdOpcode, regRdAddr, regWrAddr;
   logic signed [15:0] cmdRegNum;
   logic [15:0] cmdAddr, internal_status_word, nvWrAddr, nvWrData, pbWrAddr, pbWrData;
   logic [31:0] cmdData, regRdData, regWrData, rnd;
   int error_cnt = 0, tests_run = 0, seed = 34, lat, nErr, nHalt;
   logic [31:0] nvQ[$], pbQ[$];

   nvspc_exec #(.ADDR_W(16), .PROT_LIMIT(16)) u_nvspc_exec (.clk_sys(clk_sys), .rst(rst),
      .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdThread(cmdThread), .cmdOpcode(cmdOpcode),
      .cmdRegNum(cmdRegNum), .cmdAddr(cmdAddr), .cmdData(cmdData), .ackPulse(ackPulse),
      .cmdError(cmdError), .haltReq(haltReq), .internal_status_word(internal_status_word),
      .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
      .regWrData(regWrData), .nvWrEn(nvWrEn), .nvWrAddr(nvWrAddr), .nvWrData(nvWrData),
      .pbWrEn(pbWrEn), .pbWrAddr(pbWrAddr), .pbWrData(pbWrData));
   nvspc_reg_model u_nvspc_reg_model (.clk_sys(clk_sys), .regRdAddr(regRdAddr), .regRdData(regRdData),
      .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData));

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Outputs stand one cycle, so the falling edge sees each pulse once
   always @(negedge clk_sys) begin
      if (nvWrEn === 1'b1) nvQ.push_back({nvWrAddr, nvWrData});
      if (pbWrEn === 1'b1) pbQ.push_back({pbWrAddr, pbWrData});
      if (cmdError === 1'b1) nErr++;
      if (haltReq === 1'b1) nHalt++;
   end

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic logic [15:0] cks(input logic [31:0] v);
      return ~(v[15:0] + v[31:16]);
   endfunction

   // One command, held until taken; lat counts falling edges to the ack
   task automatic cmd(input logic [7:0] op, input logic signed [15:0] rn, input logic [15:0] ad,
      input logic [31:0] dt);
      nvQ.delete();
      pbQ.delete();
      nErr = 0;
      nHalt = 0;
      @(negedge clk_sys);
      for (int n = 0; n < 20 && cmdReady !== 1'b1; n++) @(negedge clk_sys);
      rnd = $random(seed);
      cmdThread = rnd[0];
      cmdOpcode = op;
      cmdRegNum = rn;
      cmdAddr = ad;
      cmdData = dt;
      cmdValid = 1'b1;
      @(posedge clk_sys);
      for (lat = 1; lat < 40; lat++) begin
         @(negedge clk_sys);
         cmdValid = 1'b0;
         if (ackPulse === 1'b1) break;
      end
      // Let the register model's write land before callers look at it
      @(negedge clk_sys);
   endtask
   task automatic wreg(input logic [7:0] r, input logic [31:0] v);
      cmd(`NVSPC_OP_WRITE_REG, {8'h0, r}, 16'h0, v);
      check(lat, 2);
      check(u_nvspc_reg_model.mem[r], v);
   endtask
   task automatic store(input logic signed [15:0] rn, input logic [15:0] ad, input logic [15:0] base,
      input logic [31:0] v);
      cmd(`NVSPC_OP_STORE_ONE, rn, ad, 32'h0);
      check(lat, 7);
      check(nvQ.size(), 3);
      if (nvQ.size() == 3) begin
         check(nvQ[0], {base, v[15:0]});
         check(nvQ[1], {base + 16'h1, v[31:16]});
         check(nvQ[2], {base + 16'h2, cks(v)});
      end
      check(internal_status_word[15], 1'b0);
   endtask
   task automatic patch(input logic lng, input logic [7:0] r, input logic [15:0] ad, input logic [31:0] v);
      cmd(lng ? `NVSPC_OP_PATCH_LONG : `NVSPC_OP_PATCH_WORD, {8'h0, r}, ad, 32'h0);
      check(lat, 4);
      check(pbQ.size(), lng ? 2 : 1);
      if (pbQ.size() > 0) check(pbQ[0], {ad, v[15:0]});
      if (lng && pbQ.size() == 2) check(pbQ[1], {ad + 16'h1, v[31:16]});
   endtask
   task automatic prot(input logic signed [15:0] rn);
      cmd(`NVSPC_OP_STORE_ONE, rn, 16'h000F, 32'h0);
      check(lat < 40, 1'b1);
      check(nvQ.size(), 0);
      check(nErr, 1);
      check(nHalt, rn >= 0);
      check({internal_status_word[15:14], internal_status_word[12]}, 3'h7);
   endtask

   initial begin : main
      logic [7:0] r;
      logic [15:0] a;
      logic [31:0] v;
      rst = 1'b1;
      cmdValid = 1'b0;
      cmdThread = 1'b0;
      cmdOpcode = 8'h00;
      cmdRegNum = 16'sh0000;
      cmdAddr = 16'h0000;
      cmdData = 32'h0;
      repeat (3) @(negedge clk_sys);
      rst = 1'b0;
      // Corners: sum overflow at the first writable address, indirect, top of buffer
      wreg(8'h14, 32'hFFFF_FFFF);
      store(16'sh0014, 16'h0010, 16'h0010, 32'hFFFF_FFFF);
      wreg(8'h0A, 32'h0000_0640);
      store(-16'sh0014, 16'h0000, 16'h0640, 32'hFFFF_FFFF);
      patch(1'b1, 8'h14, 16'hFFFE, 32'hFFFF_FFFF);
      prot(16'sh0014);
      prot(-16'sh0014);
      store(16'sh0014, 16'h0020, 16'h0020, 32'hFFFF_FFFF);
      cmd(8'h00, 16'sh0014, 16'h0020, 32'h0);
      check(lat, 2);
      check(nvQ.size() + pbQ.size(), 0);
      for (int i = 0; i < 12; i++) begin
         rnd = $random(seed);
         r = 8'h10 + {1'b0, rnd[6:0]};
         a = 16'h0010 + {4'h0, rnd[19:8]};
         v = $random(seed);
         wreg(r, v);
         case (rnd[21:20])
            2'd0: store(rnd[22] ? -$signed({8'h0, r}) : $signed({8'h0, r}), a, a, v);
            2'd1: patch(1'b0, r, a, v);
            default: patch(1'b1, r, a, v);
         endcase
      end
      end_of_test();
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      end_of_test();
   end
endmodule // testbench
